// File: ref_pkg.sv
// Operation
// - Add the three phase phasors into the zero-sequence phasor for later stages.
// - Flag directional start when zero-sequence and neutral differ beyond 90 degrees.
// - Bias current is the largest of the four fundamental magnitudes.
// - Base sensitivity spans 10 to 50 percent, unit steps, default 30.
// - Slope spans 50 to 100 percent of bias, unit steps, default 70.
// - Bias breakpoint spans 100 to 200 percent, unit steps, default 125.
// - Internal trip is set while differential current is above the curve.
// - Sensitivity input makes the base sensitivity four times more sensitive.
// - Operation selects Off or On, default On; Off forbids any trip.
// - Directional blocking acts only while directional check is enabled, default true.
// - General trip needs internal trip, operation On and no blocking.
// - Blocking is enabled directional start, or the external block input.
// - Differential and bias currents are output in percent for display.
// - Directional start status is also an output beside the general trip.
package ref_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SET = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MEAS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam int CTRL_OPER_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int SET_BASE_LSB = 0;
  localparam int SET_SLOPE_LSB = 8;
  localparam int SET_BRK_LSB = 16;
  localparam int STAT_TRIP_BIT = 0;
  localparam int STAT_DIR_BIT = 1;
  localparam int STAT_CHAR_BIT = 2;
  localparam int MEAS_DIFF_LSB = 0;
  localparam int MEAS_BIAS_LSB = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIP_BIT = 0;
  localparam int IRQ_DIR_BIT = 1;
  localparam logic [7:0] BASE_MIN = 8'h0a;
  localparam logic [7:0] BASE_MAX = 8'h32;
  localparam logic [7:0] BASE_DEF = 8'h1e;
  localparam logic [7:0] SLOPE_MIN = 8'h32;
  localparam logic [7:0] SLOPE_MAX = 8'h64;
  localparam logic [7:0] SLOPE_DEF = 8'h46;
  localparam logic [7:0] BRK_MIN = 8'h64;
  localparam logic [7:0] BRK_MAX = 8'hc8;
  localparam logic [7:0] BRK_DEF = 8'h7d;
  localparam logic [31:0] PCT_SCALE = 32'h64;
  localparam logic [31:0] SENS_GAIN = 32'h4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic {OPER_OFF = 1'b0, OPER_ON = 1'b1} ref_oper_type;
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } ref_phasor_type;
  typedef struct packed {
    logic signed [17:0] re;
    logic signed [17:0] im;
  } ref_wphasor_type;
  typedef struct packed {
    ref_phasor_type phase1Fundamental;
    ref_phasor_type phase2Fundamental;
    ref_phasor_type phase3Fundamental;
    ref_phasor_type neutralFundamental;
    logic [15:0] phase1Mag;
    logic [15:0] phase2Mag;
    logic [15:0] phase3Mag;
    logic [15:0] neutralMag;
  } ref_currents_type;
  typedef struct packed {
    logic [7:0] baseSensitivitySetting;
    logic [7:0] slopeSetting;
    logic [7:0] biasBreakpointSetting;
  } ref_settings_type;
  function automatic logic [7:0] clampSet(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic [19:0] isqrt(input logic [39:0] v);
    logic [19:0] r;
    logic [19:0] c;
    r = 20'h0;
    for (int i = 19; i >= 0; i--) begin
      c = r | (20'h1 << i);
      if ({20'h0, c} * {20'h0, c} <= v) r = c;
    end
    return r;
  endfunction
endpackage

// File: ref_zs_dir.sv
`timescale 1ns/1ps
module ref_zs_dir (
  input ref_pkg::ref_currents_type curr, // Phase and neutral fundamentals
  output ref_pkg::ref_wphasor_type zeroSeq, // Computed 3I0 phasor
  output logic dirStart, // Angle outside quadrature
  output logic [15:0] diffMag // Neutral minus 3I0 magnitude
);
  logic signed [34:0] dot;
  logic signed [18:0] dRe;
  logic signed [18:0] dIm;
  logic [39:0] sq;
  logic [19:0] root;
  always_comb begin
    zeroSeq.re = 18'(curr.phase1Fundamental.re) + 18'(curr.phase2Fundamental.re)
               + 18'(curr.phase3Fundamental.re);
    zeroSeq.im = 18'(curr.phase1Fundamental.im) + 18'(curr.phase2Fundamental.im)
               + 18'(curr.phase3Fundamental.im);
    // Negative dot product of the two phasors means beyond plus or minus 90 degrees
    dot = 35'(zeroSeq.re) * 35'(curr.neutralFundamental.re)
        + 35'(zeroSeq.im) * 35'(curr.neutralFundamental.im);
    dirStart = dot < 35'sh0;
    dRe = 19'(curr.neutralFundamental.re) - 19'(zeroSeq.re);
    dIm = 19'(curr.neutralFundamental.im) - 19'(zeroSeq.im);
    sq = 40'(38'(dRe * dRe)) + 40'(38'(dIm * dIm));
    root = ref_pkg::isqrt(sq);
    diffMag = (root[19:16] != 4'h0) ? 16'hffff : root[15:0];
  end
endmodule // ref_zs_dir

// File: ref_char_eval.sv
`timescale 1ns/1ps
module ref_char_eval (
  input ref_pkg::ref_currents_type curr, // Fundamental magnitudes
  input logic [15:0] diffMag, // Differential current, percent
  input ref_pkg::ref_settings_type set, // Characteristic settings
  input logic sensX4, // Fourfold sensitivity request
  output logic [15:0] biasMag, // Restraint current, percent
  output logic charTrip // Above the curve
);
  logic [15:0] brkWide;
  logic [31:0] excess;
  logic [31:0] lhs;
  logic [31:0] rhs;
  always_comb begin
    biasMag = ref_pkg::max16(ref_pkg::max16(curr.phase1Mag, curr.phase2Mag),
                             ref_pkg::max16(curr.phase3Mag, curr.neutralMag));
    brkWide = {8'h00, set.biasBreakpointSetting};
    excess = (biasMag > brkWide) ? 32'(biasMag - brkWide) : 32'h0;
    // Scaled by four hundred so the quarter base stays exact
    lhs = 32'(diffMag) * ref_pkg::SENS_GAIN * ref_pkg::PCT_SCALE;
    rhs = 32'(set.baseSensitivitySetting) * ref_pkg::PCT_SCALE
        * (sensX4 ? 32'h1 : ref_pkg::SENS_GAIN)
        + 32'(set.slopeSetting) * ref_pkg::SENS_GAIN * excess;
    charTrip = lhs > rhs;
  end
endmodule // ref_char_eval

// File: ref_trip_logic.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ref_trip_logic (
  input logic clock, // System clock
  input logic rst_b, // Asynchronous reset
  input logic hsel, // Slave select
  input logic [31:0] haddr, // Byte address
  input logic [1:0] htrans, // Transfer type
  input logic hwrite, // Write direction
  input logic [2:0] hsize, // Transfer size
  input logic [31:0] hwdata, // Write data
  input logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic [31:0] hrdata, // Read data
  input logic fourierValid, // New Fourier result set
  input ref_pkg::ref_currents_type currents, // Fundamental results
  input logic sensitivityX4Input, // Raise sensitivity fourfold
  input logic externalBlockInput, // Block the general trip
  output logic generalTripOut, // General trip
  output logic dirBlockStatus, // Directional start status
  output logic [15:0] diffCurrentMeas, // Differential current
  output logic [15:0] biasCurrentMeas, // Restraint current
  output logic irq // Interrupt level
);
  logic [1:0] rstSync;
  logic rstSync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSync_b = rstSync[1];

  ref_pkg::ref_wphasor_type zeroSeqW;
  logic dirStartW;
  logic [15:0] diffW;
  logic [15:0] biasW;
  logic charW;
  ref_pkg::ref_settings_type settings_reg;
  ref_pkg::ref_settings_type settings_next;

  ref_zs_dir uZsDir (
    .curr(currents),
    .zeroSeq(zeroSeqW),
    .dirStart(dirStartW),
    .diffMag(diffW)
  );

  ref_char_eval uChar (
    .curr(currents),
    .diffMag(diffW),
    .set(settings_reg),
    .sensX4(sensitivityX4Input),
    .biasMag(biasW),
    .charTrip(charW)
  );

  // Bus slave: zero wait states, read data latched at the address phase
  logic accept;
  logic wrPend_reg;
  logic wrPend_next;
  logic [7:0] wrAddr_reg;
  logic [7:0] wrAddr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  ref_pkg::ref_oper_type operation_reg;
  ref_pkg::ref_oper_type operation_next;
  logic dirCheck_reg;
  logic dirCheck_next;
  logic charTrip_reg;
  logic charTrip_next;
  logic dirStat_reg;
  logic dirStat_next;
  logic [15:0] diffMeas_reg;
  logic [15:0] diffMeas_next;
  logic [15:0] biasMeas_reg;
  logic [15:0] biasMeas_next;
  logic trip_reg;
  logic trip_next;
  logic [1:0] irqStatus_reg;
  logic [1:0] irqStatus_next;
  logic [1:0] irqMask_reg;
  logic [1:0] irqMask_next;
  logic irq_reg;
  logic irq_next;
  logic [1:0] events;
  logic [1:0] w1c;

  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    wrPend_next = accept && hwrite && (hsize == ref_pkg::HSIZE_WORD);
    wrAddr_next = accept ? haddr[7:0] : wrAddr_reg;
    hrdata_next = hrdata_reg;
    if (accept && !hwrite) begin
      hrdata_next = 32'h0;
      case (haddr[7:0])
        ref_pkg::ADDR_CTRL: begin
          hrdata_next[ref_pkg::CTRL_OPER_BIT] = (operation_reg == ref_pkg::OPER_ON);
          hrdata_next[ref_pkg::CTRL_DIR_BIT] = dirCheck_reg;
        end
        ref_pkg::ADDR_SET: begin
          hrdata_next[ref_pkg::SET_BASE_LSB +: 8] = settings_reg.baseSensitivitySetting;
          hrdata_next[ref_pkg::SET_SLOPE_LSB +: 8] = settings_reg.slopeSetting;
          hrdata_next[ref_pkg::SET_BRK_LSB +: 8] = settings_reg.biasBreakpointSetting;
        end
        ref_pkg::ADDR_STAT: begin
          hrdata_next[ref_pkg::STAT_TRIP_BIT] = trip_reg;
          hrdata_next[ref_pkg::STAT_DIR_BIT] = dirStat_reg;
          hrdata_next[ref_pkg::STAT_CHAR_BIT] = charTrip_reg;
        end
        ref_pkg::ADDR_MEAS: begin
          hrdata_next[ref_pkg::MEAS_DIFF_LSB +: 16] = diffMeas_reg;
          hrdata_next[ref_pkg::MEAS_BIAS_LSB +: 16] = biasMeas_reg;
        end
        ref_pkg::ADDR_IRQ_STAT: begin
          hrdata_next[ref_pkg::IRQ_W-1:0] = irqStatus_reg;
        end
        ref_pkg::ADDR_IRQ_MASK: begin
          hrdata_next[ref_pkg::IRQ_W-1:0] = irqMask_reg;
        end
        default: begin
          hrdata_next = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = ref_pkg::HRESP_OKAY;
  assign hrdata = hrdata_reg;

  // Configuration; settings outside their span are clamped to the nearest bound
  always_comb begin
    operation_next = operation_reg;
    dirCheck_next = dirCheck_reg;
    settings_next = settings_reg;
    if (wrPend_reg && wrAddr_reg == ref_pkg::ADDR_CTRL) begin
      operation_next = hwdata[ref_pkg::CTRL_OPER_BIT] ? ref_pkg::OPER_ON
                                                      : ref_pkg::OPER_OFF;
      dirCheck_next = hwdata[ref_pkg::CTRL_DIR_BIT];
    end
    if (wrPend_reg && wrAddr_reg == ref_pkg::ADDR_SET) begin
      settings_next.baseSensitivitySetting = ref_pkg::clampSet(
        hwdata[ref_pkg::SET_BASE_LSB +: 8], ref_pkg::BASE_MIN, ref_pkg::BASE_MAX);
      settings_next.slopeSetting = ref_pkg::clampSet(
        hwdata[ref_pkg::SET_SLOPE_LSB +: 8], ref_pkg::SLOPE_MIN, ref_pkg::SLOPE_MAX);
      settings_next.biasBreakpointSetting = ref_pkg::clampSet(
        hwdata[ref_pkg::SET_BRK_LSB +: 8], ref_pkg::BRK_MIN, ref_pkg::BRK_MAX);
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      operation_reg <= ref_pkg::OPER_ON;
      dirCheck_reg <= 1'b1;
      settings_reg.baseSensitivitySetting <= ref_pkg::BASE_DEF;
      settings_reg.slopeSetting <= ref_pkg::SLOPE_DEF;
      settings_reg.biasBreakpointSetting <= ref_pkg::BRK_DEF;
    end else begin
      operation_reg <= operation_next;
      dirCheck_reg <= dirCheck_next;
      settings_reg <= settings_next;
    end
  end

  // Results captured once per Fourier set; decision re-evaluated every cycle
  always_comb begin
    charTrip_next = fourierValid ? charW : charTrip_reg;
    dirStat_next = fourierValid ? dirStartW : dirStat_reg;
    diffMeas_next = fourierValid ? diffW : diffMeas_reg;
    biasMeas_next = fourierValid ? biasW : biasMeas_reg;
    trip_next = charTrip_reg && (operation_reg == ref_pkg::OPER_ON)
             && !(dirCheck_reg && dirStat_reg)
             && !externalBlockInput;
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      charTrip_reg <= 1'b0;
      dirStat_reg <= 1'b0;
      diffMeas_reg <= 16'h0;
      biasMeas_reg <= 16'h0;
      trip_reg <= 1'b0;
    end else begin
      charTrip_reg <= charTrip_next;
      dirStat_reg <= dirStat_next;
      diffMeas_reg <= diffMeas_next;
      biasMeas_reg <= biasMeas_next;
      trip_reg <= trip_next;
    end
  end

  assign generalTripOut = trip_reg;
  assign dirBlockStatus = dirStat_reg;
  assign diffCurrentMeas = diffMeas_reg;
  assign biasCurrentMeas = biasMeas_reg;

  // Interrupts: rising edges of trip and directional start; set beats clear
  always_comb begin
    events = 2'h0;
    events[ref_pkg::IRQ_TRIP_BIT] = trip_next && !trip_reg;
    events[ref_pkg::IRQ_DIR_BIT] = dirStat_next && !dirStat_reg;
    w1c = (wrPend_reg && wrAddr_reg == ref_pkg::ADDR_IRQ_STAT) ?
          hwdata[ref_pkg::IRQ_W-1:0] : 2'h0;
    irqStatus_next = (irqStatus_reg & ~w1c) | events;
    irqMask_next = (wrPend_reg && wrAddr_reg == ref_pkg::ADDR_IRQ_MASK) ?
                   hwdata[ref_pkg::IRQ_W-1:0] : irqMask_reg;
    irq_next = |(irqStatus_next & irqMask_next);
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irqStatus_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irqMask_reg <= irqMask_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSync_b);

  a_zero_seq_sum: assert property (
    zeroSeqW.re == 18'(currents.phase1Fundamental.re) + 18'(currents.phase2Fundamental.re)
                 + 18'(currents.phase3Fundamental.re))
    else $error("zero sequence sum wrong");
  a_dir_capture: assert property (
    fourierValid |=> dirBlockStatus == $past(dirStartW))
    else $error("directional status not captured");
  a_dir_opposite: assert property (
    fourierValid && zeroSeqW.re > 18'sh0 && zeroSeqW.im == 18'sh0
    && currents.neutralFundamental.re < 16'sh0 && currents.neutralFundamental.im == 16'sh0
    |=> dirBlockStatus)
    else $error("opposed currents not flagged");
  a_bias_max: assert property (
    biasW >= currents.phase1Mag && biasW >= currents.phase2Mag
    && biasW >= currents.phase3Mag && biasW >= currents.neutralMag
    && (biasW == currents.phase1Mag || biasW == currents.phase2Mag
        || biasW == currents.phase3Mag || biasW == currents.neutralMag))
    else $error("bias not the largest input");
  a_base_range: assert property (
    settings_reg.baseSensitivitySetting inside {[ref_pkg::BASE_MIN:ref_pkg::BASE_MAX]})
    else $error("base sensitivity out of span");
  a_slope_range: assert property (
    settings_reg.slopeSetting inside {[ref_pkg::SLOPE_MIN:ref_pkg::SLOPE_MAX]})
    else $error("slope out of span");
  a_brk_range: assert property (
    settings_reg.biasBreakpointSetting inside {[ref_pkg::BRK_MIN:ref_pkg::BRK_MAX]})
    else $error("breakpoint out of span");
  a_flat_char: assert property (
    fourierValid && !sensitivityX4Input
    && biasW <= {8'h00, settings_reg.biasBreakpointSetting}
    |=> charTrip_reg == ($past(diffW) > {8'h00, $past(settings_reg.baseSensitivitySetting)}))
    else $error("flat section wrong");
  a_sens_quarter: assert property (
    fourierValid && sensitivityX4Input
    && biasW <= {8'h00, settings_reg.biasBreakpointSetting}
    && 18'(diffW) * 18'h4 > 18'(settings_reg.baseSensitivitySetting)
    |=> charTrip_reg)
    else $error("fourfold sensitivity missing");
  a_char_hold: assert property (
    !fourierValid |=> $stable(charTrip_reg) && $stable(diffCurrentMeas))
    else $error("result changed without new set");
  a_meas_capture: assert property (
    fourierValid |=> diffCurrentMeas == $past(diffW) && biasCurrentMeas == $past(biasW))
    else $error("measured values not captured");
  a_off_no_trip: assert property (
    operation_reg == ref_pkg::OPER_OFF |=> !generalTripOut)
    else $error("trip while off");
  a_dir_block: assert property (
    dirCheck_reg && dirStat_reg |=> !generalTripOut)
    else $error("trip despite directional block");
  a_ext_block: assert property (
    externalBlockInput |=> !generalTripOut)
    else $error("trip despite external block");
  a_trip_follows: assert property (
    charTrip_reg && operation_reg == ref_pkg::OPER_ON && !externalBlockInput
    && !(dirCheck_reg && dirStat_reg) |=> generalTripOut)
    else $error("trip missing");
  a_trip_cause: assert property (
    generalTripOut |-> $past(charTrip_reg))
    else $error("trip without characteristic");
  a_irq_sticky: assert property (
    $rose(generalTripOut) |-> irqStatus_reg[ref_pkg::IRQ_TRIP_BIT])
    else $error("trip event not recorded");

  c_trip: cover property ($rose(generalTripOut));
  c_dir_blocked: cover property (charTrip_reg && dirStat_reg && dirCheck_reg);
  c_sens_trip: cover property (fourierValid && sensitivityX4Input ##1 charTrip_reg);
  c_irq: cover property ($rose(irq));
endmodule // ref_trip_logic

// File: ref_fourier_model.sv
`timescale 1ns/1ps
module ref_fourier_model (
  input wire logic clock, // System clock
  input wire logic sendReq, // Publish one result set
  input ref_pkg::ref_currents_type sendSet, // Set to publish
  output logic fourierValid, // One-cycle result strobe
  output ref_pkg::ref_currents_type currents // Published results
);
  initial begin
    fourierValid = 1'b0;
    currents = '0;
  end
  // Outside the strobe the results bus toggles each cycle between the inverted and the true last set
  always @(posedge clock) begin
    fourierValid <= sendReq;
    currents <= sendReq ? sendSet : ~currents;
  end
endmodule // ref_fourier_model

// File: ref_tb.sv
`timescale 1ns/1ps
module tb;
  logic clock;
  logic rst_b;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rdData;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sendReq;
  ref_pkg::ref_currents_type sendSet;
  logic fourierValid;
  ref_pkg::ref_currents_type currents;
  logic sensitivityX4Input;
  logic externalBlockInput;
  logic generalTripOut;
  logic dirBlockStatus;
  logic [15:0] diffCurrentMeas;
  logic [15:0] biasCurrentMeas;
  logic irq;
  int nFail;
  int checksDone;
  int cycles;

  ref_fourier_model prep (.clock(clock), .sendReq(sendReq), .sendSet(sendSet),
    .fourierValid(fourierValid), .currents(currents));

  ref_trip_logic DUT (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fourierValid(fourierValid),
    .currents(currents), .sensitivityX4Input(sensitivityX4Input),
    .externalBlockInput(externalBlockInput), .generalTripOut(generalTripOut),
    .dirBlockStatus(dirBlockStatus), .diffCurrentMeas(diffCurrentMeas),
    .biasCurrentMeas(biasCurrentMeas), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      nFail = nFail + 1;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone = checksDone + 1;
    if (got !== exp) begin
      nFail = nFail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= ref_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= ref_pkg::HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdData = hrdata;
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask

  task automatic settle;
    @(posedge clock);
    @(posedge clock);
    #1;
  endtask

  // Phases share one phasor, so the zero-sequence sum is three times it
  task automatic fsend(input logic signed [15:0] p, input logic signed [15:0] nre,
    input logic signed [15:0] nim, input logic [15:0] pm, input logic [15:0] nm,
    input logic sx, input logic [15:0] eDiff, input logic eDir, input logic eTrip);
    @(posedge clock);
    sendSet <= '{'{p, 16'sh0}, '{p, 16'sh0}, '{p, 16'sh0}, '{nre, nim}, pm, pm, pm, nm};
    sendReq <= 1'b1;
    sensitivityX4Input <= sx;
    @(posedge clock);
    sendReq <= 1'b0;
    settle;
    chk(diffCurrentMeas, eDiff);
    chk(biasCurrentMeas, (pm > nm) ? pm : nm);
    chk(dirBlockStatus, eDir);
    chk(generalTripOut, eTrip);
  endtask

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    sendReq = 1'b0;
    sendSet = '0;
    sensitivityX4Input = 1'b0;
    externalBlockInput = 1'b0;
    nFail = 0;
    checksDone = 0;
    cycles = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(generalTripOut, 1'b0);
    chkReg(ref_pkg::ADDR_CTRL, 32'h00000003);
    chkReg(ref_pkg::ADDR_SET, 32'h007d461e);
    chkReg(ref_pkg::ADDR_IRQ_MASK, 32'h00000000);
    chkReg(8'h18, 32'h00000000);
    ahb(1'b1, ref_pkg::ADDR_IRQ_STAT, 32'h00000003);
    ahb(1'b1, ref_pkg::ADDR_IRQ_MASK, 32'h00000001);
    fsend(16'sd10, 16'sd80, 16'sd0, 16'h14, 16'h50, 1'b0, 16'h32, 1'b0, 1'b1);
    chk(irq, 1'b1);
    ahb(1'b1, ref_pkg::ADDR_IRQ_STAT, 32'h00000001);
    settle;
    chk(irq, 1'b0);
    // Slope section: threshold 33000 at bias 200
    fsend(16'sd10, 16'sd112, 16'sd0, 16'hc8, 16'h70, 1'b0, 16'h52, 1'b0, 1'b0);
    fsend(16'sd10, 16'sd113, 16'sd0, 16'hc8, 16'h71, 1'b0, 16'h53, 1'b0, 1'b1);
    fsend(16'sd10, 16'sd37, 16'sd0, 16'h14, 16'h25, 1'b1, 16'h07, 1'b0, 1'b0);
    fsend(16'sd10, 16'sd38, 16'sd0, 16'h14, 16'h26, 1'b1, 16'h08, 1'b0, 1'b1);
    fsend(16'sd10, 16'sd38, 16'sd0, 16'h14, 16'h26, 1'b0, 16'h08, 1'b0, 1'b0);
    ahb(1'b1, ref_pkg::ADDR_IRQ_STAT, 32'h00000003);
    fsend(16'sd10, -16'sd50, 16'sd0, 16'h14, 16'h32, 1'b0, 16'h50, 1'b1, 1'b0);
    chkReg(ref_pkg::ADDR_STAT, 32'h00000006);
    chkReg(ref_pkg::ADDR_IRQ_STAT, 32'h00000002);
    chk(irq, 1'b0);
    ahb(1'b1, ref_pkg::ADDR_CTRL, 32'h00000001);
    settle;
    chk(generalTripOut, 1'b1);
    chk(irq, 1'b1);
    ahb(1'b1, ref_pkg::ADDR_CTRL, 32'h00000003);
    fsend(16'sd10, 16'sd0, 16'sd50, 16'h14, 16'h32, 1'b0, 16'h3a, 1'b0, 1'b1);
    chkReg(ref_pkg::ADDR_MEAS, 32'h0032003a);
    chk(hresp, {31'h0, ref_pkg::HRESP_OKAY});
    @(posedge clock);
    externalBlockInput <= 1'b1;
    settle;
    chk(generalTripOut, 1'b0);
    @(posedge clock);
    externalBlockInput <= 1'b0;
    settle;
    chk(generalTripOut, 1'b1);
    ahb(1'b1, ref_pkg::ADDR_CTRL, 32'h00000002);
    settle;
    chk(generalTripOut, 1'b0);
    ahb(1'b1, ref_pkg::ADDR_CTRL, 32'h00000003);
    settle;
    chk(generalTripOut, 1'b1);
    ahb(1'b1, ref_pkg::ADDR_SET, 32'h00ff0005);
    chkReg(ref_pkg::ADDR_SET, 32'h00c8320a);
    ahb(1'b1, ref_pkg::ADDR_SET, 32'h00c86432);
    chkReg(ref_pkg::ADDR_SET, 32'h00c86432);
    // Reset in mid-run while the trip stands
    @(posedge clock);
    rst_b <= 1'b0;
    settle;
    chk(generalTripOut, 1'b0);
    chk(diffCurrentMeas, 32'h0);
    @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(generalTripOut, 1'b0);
    chkReg(ref_pkg::ADDR_SET, 32'h007d461e);
    chkReg(ref_pkg::ADDR_CTRL, 32'h00000003);
    complete_run;
  end
endmodule // tb
